/* File: design/cssc_cfg.svh */
`ifndef CSSC_CFG_SVH
`define CSSC_CFG_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define CSSC_AW            8
`define CSSC_DW            32
`define CSSC_OFF_CTRL      8'h00
`define CSSC_OFF_DIV       8'h04
`define CSSC_OFF_TXBUF     8'h08
`define CSSC_OFF_RXBUF     8'h0C
`define CSSC_OFF_STAT      8'h10

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define CSSC_CTRL_W        13
`define CSSC_CTRL_RST      13'h0000
`define CSSC_DIV_W         8
`define CSSC_DIV_RST       8'h00
`define CSSC_ST_TXEMPTY    0
`define CSSC_ST_RXDONE     1
`define CSSC_ST_OVR        2
`define CSSC_ST_TXIRQ      3
`define CSSC_ST_RXIRQ      4
`define CSSC_ST_BUFEMPTY   5
`define CSSC_ST_BUFFULL    6
`define CSSC_LINE_RST      1'b1

// ----------------------------------------------------------------
// count sources and framing
// ----------------------------------------------------------------
`define CSSC_SRC_F1        2'h0
`define CSSC_SRC_F8        2'h1
`define CSSC_PRE_W         5
`define CSSC_PRE_F8        3'h7
`define CSSC_PRE_F32       5'h1F
`define CSSC_CNT_W         4
`define CSSC_LAST_BIT      4'h7
`define CSSC_WORD_W        8
`define CSSC_FIFO_DEPTH    8
`define CSSC_DUMMY         8'hFF

`endif

/* File: design/cssc_pkg.sv */
`default_nettype none
`include "cssc_cfg.svh"

package cssc_pkg;

  // control register, msb first
  typedef struct packed {
    logic [1:0] src_sel;
    logic       cont_rx;
    logic       clk_pin_sel;
    logic       flow_en;
    logic       txirq_done;
    logic       pin_inv;
    logic       data_inv;
    logic       lsb_first;
    logic       clk_pol;
    logic       clk_ext;
    logic       rx_en;
    logic       tx_en;
  } cssc_ctrl_s;

  typedef enum logic {CSSC_IDLE, CSSC_SHIFT} cssc_state_e;

  typedef struct packed {
    logic txd;
    logic rts_n;
    logic clk0;
    logic clk0_oe;
    logic clk1;
    logic clk1_oe;
  } cssc_pins_s;

  typedef struct packed {
    cssc_ctrl_s                 ctrl;
    logic [`CSSC_DIV_W-1:0]     div;
    cssc_state_e                state;
    logic [`CSSC_PRE_W-1:0]     pre;
    logic [`CSSC_DIV_W-1:0]     brg;
    logic                       sclk;
    logic                       ext_prev;
    logic [`CSSC_CNT_W-1:0]     bitcnt;
    logic [`CSSC_WORD_W-1:0]    tx_sh;
    logic [`CSSC_WORD_W-1:0]    rx_sh;
    logic [`CSSC_WORD_W-1:0]    rx_buf;
    logic                       rx_full;
    logic                       ovr;
    logic                       tx_irq;
    logic                       rx_irq;
    logic                       txd;
    logic                       rts_n;
    logic [`CSSC_DW-1:0]        rdata;
  } cssc_regs_s;

endpackage

`default_nettype wire

/* File: design/cssc_top.sv */
// Functional notes
// [RL1] software picks which clock edge changes tx data and samples rx data
// [RL2] words shift msb first or lsb first, both directions
// [RL3] data inversion flips tx data on write and rx data on read
// [RL4] pin inversion flips txd output level and rxd input level
// [RL5] tx request raised on buffer empty or on word complete, selectable
// [RL6] flow control: wait for cts before sending, drive rts when ready
// [RL7] error flag for failed receive; only overrun is detected
// [RL8] two clock output pins, clock driven on the selected one
// [RL9] continuous receive: one dummy write, then each read enables next word
// [RL10] transmission starts only with tx enable set and a buffer write
// [RL11] completion shown by request bits, tx-empty and rx-complete flags
// [RL12] both directions double buffered
// [RL13] internal clock: device drives clock and shifts on buffer write
// [RL14] external clock: shift only on peer clock after enable and load
// [RL15] bit rate is source over 2(n+1), three prescaled sources
// [RL16] receive needs tx and rx enable, started by dummy write
// [RL17] buffer-empty source: request when word moves into shift register
// [RL18] continuous receive: rx buffer read acts as dummy tx write
// [RL19] overrun when a word completes while previous one is unread
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cssc_cfg.svh"

// ----------------------------------------------------------------
// transmit fifo
// ----------------------------------------------------------------
module cssc_fifo #(
  parameter int W = `CSSC_WORD_W,
  parameter int D = `CSSC_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [PW-1:0] LAST = PW'(D - 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } cssc_fifo_st_s;

  cssc_fifo_st_s q;
  cssc_fifo_st_s d;
  logic [W-1:0]  mem [D];
  logic          push;
  logic          pop;

  assign in_ready  = (q.cnt != FULL);
  assign out_valid = (q.cnt != '0);
  assign out_data  = mem[q.rp];

  always_comb begin
    d    = q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      d.wp = (q.wp == LAST) ? '0 : PW'(q.wp + 1'b1);
    end
    if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : PW'(q.rp + 1'b1);
    end
    case ({push, pop})
      2'b10:   d.cnt = CW'(q.cnt + 1'b1);
      2'b01:   d.cnt = CW'(q.cnt - 1'b1);
      default: d.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end

endmodule // cssc_fifo

// ----------------------------------------------------------------
// serial channel
// ----------------------------------------------------------------
module cssc_top (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [`CSSC_AW-1:0]    addr,
  input  wire logic [`CSSC_DW-1:0]    wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [`CSSC_DW-1:0]    rdata,
  output logic                        tx_ready,
  input  wire logic                   rxd_i,
  input  wire logic                   cts_n_i,
  input  wire logic                   ext_clk_i,
  output cssc_pkg::cssc_pins_s        pins_o
);

  cssc_pkg::cssc_regs_s      q;
  cssc_pkg::cssc_regs_s      d;
  logic                      fifo_push;
  logic [`CSSC_WORD_W-1:0]   fifo_wdata;
  logic                      fifo_valid;
  logic [`CSSC_WORD_W-1:0]   fifo_rdata;
  logic                      start;
  logic                      done;
  logic                      src_en;
  logic                      tick;
  logic                      idle_lvl;
  logic                      chg_edge;
  logic                      smp_edge;
  logic                      rx_bit;
  logic [`CSSC_WORD_W-1:0]   rx_next;
  logic                      shifting;

  // [RL12] transmit side buffered ahead of the shift register
  cssc_fifo #(
    .W (`CSSC_WORD_W),
    .D (`CSSC_FIFO_DEPTH)
  ) u_txfifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fifo_push),
    .in_ready  (tx_ready),
    .in_data   (fifo_wdata),
    .out_valid (fifo_valid),
    .out_ready (start),
    .out_data  (fifo_rdata)
  );

  assign rdata    = q.rdata;
  assign shifting = (q.state == cssc_pkg::CSSC_SHIFT);
  // the first edge away from idle is always the change edge
  assign idle_lvl = ~q.ctrl.clk_pol;

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // [RL8] clock on the selected pin only
  always_comb begin
    pins_o.txd     = q.txd;
    pins_o.rts_n   = q.rts_n;
    pins_o.clk0    = q.sclk;
    pins_o.clk1    = q.sclk;
    pins_o.clk0_oe = ~q.ctrl.clk_ext & ~q.ctrl.clk_pin_sel;
    pins_o.clk1_oe = ~q.ctrl.clk_ext & q.ctrl.clk_pin_sel;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    fifo_push  = 1'b0;
    fifo_wdata = '0;
    tick       = 1'b0;
    chg_edge   = 1'b0;
    smp_edge   = 1'b0;
    done       = 1'b0;
    rx_bit     = rxd_i ^ q.ctrl.pin_inv;
    rx_next    = q.rx_sh;
    d.rdata    = '0;
    d.pre      = `CSSC_PRE_W'(q.pre + 1'b1);
    d.ext_prev = ext_clk_i;

    // [RL15] count source select
    case (q.ctrl.src_sel)
      `CSSC_SRC_F1: src_en = 1'b1;
      `CSSC_SRC_F8: src_en = (q.pre[2:0] == `CSSC_PRE_F8);
      default:      src_en = (q.pre == `CSSC_PRE_F32);
    endcase

    // register writes; clears come first so hardware sets win
    if (wr) begin
      case (addr)
        `CSSC_OFF_CTRL: d.ctrl = cssc_pkg::cssc_ctrl_s'(wdata[`CSSC_CTRL_W-1:0]);
        `CSSC_OFF_DIV:  d.div  = wdata[`CSSC_DIV_W-1:0];
        `CSSC_OFF_TXBUF: begin
          // [RL10] writes while disabled are dropped
          fifo_push  = q.ctrl.tx_en;
          // [RL3] invert on write
          fifo_wdata = wdata[`CSSC_WORD_W-1:0] ^ {`CSSC_WORD_W{q.ctrl.data_inv}};
        end
        `CSSC_OFF_STAT: begin
          if (wdata[`CSSC_ST_OVR]) begin
            d.ovr = 1'b0;
          end
          if (wdata[`CSSC_ST_TXIRQ]) begin
            d.tx_irq = 1'b0;
          end
          if (wdata[`CSSC_ST_RXIRQ]) begin
            d.rx_irq = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (rd) begin
      case (addr)
        `CSSC_OFF_CTRL: d.rdata = `CSSC_DW'(q.ctrl);
        `CSSC_OFF_DIV:  d.rdata = `CSSC_DW'(q.div);
        `CSSC_OFF_RXBUF: begin
          // [RL3] invert on read
          d.rdata   = `CSSC_DW'(q.rx_buf ^ {`CSSC_WORD_W{q.ctrl.data_inv}});
          d.rx_full = 1'b0;
          // [RL18] read doubles as dummy write
          if (q.ctrl.cont_rx) begin
            fifo_push  = 1'b1;
            fifo_wdata = `CSSC_DUMMY;
          end
        end
        `CSSC_OFF_STAT: begin
          // [RL11] completion flags
          d.rdata[`CSSC_ST_TXEMPTY]  = ~shifting;
          d.rdata[`CSSC_ST_RXDONE]   = q.rx_full;
          d.rdata[`CSSC_ST_OVR]      = q.ovr;
          d.rdata[`CSSC_ST_TXIRQ]    = q.tx_irq;
          d.rdata[`CSSC_ST_RXIRQ]    = q.rx_irq;
          d.rdata[`CSSC_ST_BUFEMPTY] = ~fifo_valid;
          d.rdata[`CSSC_ST_BUFFULL]  = ~tx_ready;
        end
        default: d.rdata = '0;
      endcase
    end

    // [RL6] hold off until peer allows; [RL10] [RL16] needs tx enable
    start = ~shifting && q.ctrl.tx_en && fifo_valid && (~q.ctrl.flow_en || ~cts_n_i);

    // [RL13] internal bit-rate generator runs only within a word
    if (shifting && ~q.ctrl.clk_ext && src_en) begin
      if (q.brg == '0) begin
        tick  = 1'b1;
        d.brg = q.div;
      end else begin
        d.brg = `CSSC_DIV_W'(q.brg - 1'b1);
      end
    end

    // [RL1] edge roles follow the clock polarity choice
    if (q.ctrl.clk_ext) begin
      // [RL14] peer clock, only while a word is loaded
      chg_edge = shifting && (ext_clk_i != q.ext_prev) && (q.ext_prev == idle_lvl);
      smp_edge = shifting && (ext_clk_i != q.ext_prev) && (q.ext_prev != idle_lvl);
    end else begin
      chg_edge = tick && (q.sclk == idle_lvl);
      smp_edge = tick && (q.sclk != idle_lvl);
    end
    if (tick) begin
      d.sclk = ~q.sclk;
    end

    case (q.state)
      cssc_pkg::CSSC_IDLE: begin
        d.sclk = idle_lvl;
        d.txd  = ~q.ctrl.pin_inv;
        if (start) begin
          d.state  = cssc_pkg::CSSC_SHIFT;
          d.tx_sh  = fifo_rdata;
          d.bitcnt = '0;
          d.brg    = q.div;
          // [RL17] [RL5] buffer-empty request on transfer to shifter
          if (~q.ctrl.txirq_done) begin
            d.tx_irq = 1'b1;
          end
        end
      end
      cssc_pkg::CSSC_SHIFT: begin
        if (chg_edge) begin
          // [RL2] [RL4] next bit out, pin polarity applied
          if (q.ctrl.lsb_first) begin
            d.txd   = q.tx_sh[0] ^ q.ctrl.pin_inv;
            d.tx_sh = {1'b0, q.tx_sh[`CSSC_WORD_W-1:1]};
          end else begin
            d.txd   = q.tx_sh[`CSSC_WORD_W-1] ^ q.ctrl.pin_inv;
            d.tx_sh = {q.tx_sh[`CSSC_WORD_W-2:0], 1'b0};
          end
        end
        if (smp_edge) begin
          // [RL2] [RL4] bit in, same order as out
          if (q.ctrl.lsb_first) begin
            rx_next = {rx_bit, q.rx_sh[`CSSC_WORD_W-1:1]};
          end else begin
            rx_next = {q.rx_sh[`CSSC_WORD_W-2:0], rx_bit};
          end
          d.rx_sh  = rx_next;
          d.bitcnt = `CSSC_CNT_W'(q.bitcnt + 1'b1);
          done     = (q.bitcnt == `CSSC_LAST_BIT);
        end
        if (done) begin
          d.state = cssc_pkg::CSSC_IDLE;
          // [RL5] word-complete request
          if (q.ctrl.txirq_done) begin
            d.tx_irq = 1'b1;
          end
          // [RL16] receive kept only with rx enable
          if (q.ctrl.rx_en) begin
            // [RL19] [RL7] unread word overwritten, overrun flagged
            if (d.rx_full) begin
              d.ovr = 1'b1;
            end
            // [RL12] receive buffer frees the shift register
            d.rx_buf  = rx_next;
            d.rx_full = 1'b1;
            d.rx_irq  = 1'b1;
          end
        end
      end
      default: d.state = cssc_pkg::CSSC_IDLE;
    endcase

    // [RL6] ready to receive while the buffer is free
    d.rts_n = ~(q.ctrl.flow_en && q.ctrl.rx_en && ~q.rx_full);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.ctrl  <= cssc_pkg::cssc_ctrl_s'(`CSSC_CTRL_RST);
      q.div   <= `CSSC_DIV_RST;
      q.ext_prev <= `CSSC_LINE_RST;
      q.sclk  <= `CSSC_LINE_RST;
      q.txd   <= `CSSC_LINE_RST;
      q.rts_n <= `CSSC_LINE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence start_s;
    start && ~q.ctrl.clk_ext && (q.ctrl.src_sel == `CSSC_SRC_F1) && (q.div == '0);
  endsequence

  sequence done_s;
    done;
  endsequence

  a_start_needs_en: assert property (~shifting ##1 shifting |-> $past(q.ctrl.tx_en && fifo_valid)) // RL10
    else $error("word started without transmit enable");

  a_cts_holds_tx: assert property (~shifting ##1 shifting |-> $past(~q.ctrl.flow_en || ~cts_n_i)) // RL6
    else $error("word started while cts deasserted");

  a_rts_ready: assert property ((q.ctrl.flow_en && q.ctrl.rx_en && ~q.rx_full) |=> ~pins_o.rts_n) // RL6
    else $error("rts not asserted while ready");

  a_bufempty_req: assert property (start && ~q.ctrl.txirq_done |=> q.tx_irq) // RL17
    else $error("buffer-empty request missing");

  a_done_req: assert property (done && q.ctrl.txirq_done |=> q.tx_irq && ~shifting) // RL5
    else $error("complete request missing");

  a_overrun_set: assert property (done && q.ctrl.rx_en && q.rx_full && ~(rd && addr == `CSSC_OFF_RXBUF)
                                  |=> q.ovr && q.rx_full) // RL19
    else $error("overrun not flagged");

  a_cont_dummy: assert property (rd && addr == `CSSC_OFF_RXBUF && q.ctrl.cont_rx && tx_ready
                                 |=> fifo_valid || shifting) // RL18
    else $error("continuous read did not load dummy");

  a_clk_pin_sel: assert property (~(pins_o.clk0_oe && pins_o.clk1_oe)
                                  && ~(q.ctrl.clk_ext && (pins_o.clk0_oe || pins_o.clk1_oe))) // RL8
    else $error("clock driven on wrong pin");

  a_word_length: assert property (start_s |-> ##16 done_s) // RL15
    else $error("word length wrong at fastest rate");

  a_read_latency: assert property (rd && addr == `CSSC_OFF_RXBUF && ~q.ctrl.data_inv
                                   |=> rdata == `CSSC_DW'($past(q.rx_buf))) // RL3
    else $error("receive buffer read data wrong");

endmodule // cssc_top

`default_nettype wire

/* File: verif/cssc_peer.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// serial peripheral on the far side of the lines
// ----------------------------------------------------------------
module cssc_peer (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire cssc_pkg::cssc_pins_s pins,
  input  wire logic                 ext_mode,
  input  wire logic                 pol,
  input  wire logic                 go,
  input  wire logic                 push,
  input  wire logic [7:0]           push_d,
  output logic                      rxd,
  output logic                      ext_clk,
  output logic [7:0]                got,
  output logic                      got_v,
  output logic [15:0]               half
);
  logic        prev_q, busy_q, line, chg, smp;
  logic [7:0]  sh_q, d;
  logic [3:0]  cnt_q;
  logic [4:0]  tog_q;
  logic [1:0]  hc_q;
  logic [15:0] cyc_q;
  logic [7:0]  fq[$];

  assign line = ext_mode ? ext_clk : (pins.clk0_oe ? pins.clk0 : pins.clk1);
  assign chg  = line == pol && prev_q != pol;
  assign smp  = line != pol && prev_q == pol && busy_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q  <= 1'b1;
      busy_q  <= 1'b0;
      cnt_q   <= 4'h0;
      tog_q   <= 5'h00;
      hc_q    <= 2'h0;
      cyc_q   <= 16'h0000;
      sh_q    <= 8'h00;
      ext_clk <= 1'b1;
      rxd     <= 1'b1;
      got     <= 8'h00;
      got_v   <= 1'b0;
      half    <= 16'h0000;
    end else begin
      prev_q <= line;
      got_v  <= 1'b0;
      cyc_q  <= (chg || smp) ? 16'h0001 : cyc_q + 16'h0001;
      if (chg || smp) half <= cyc_q;
      if (push) fq.push_back(push_d);
      if (chg) begin
        d = busy_q ? sh_q : (fq.size() > 0 ? fq.pop_front() : 8'h00);
        rxd    <= d[7];
        sh_q   <= {d[6:0], 1'b0};
        busy_q <= 1'b1;
      end
      if (smp) begin
        got   <= {got[6:0], pins.txd};
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'h7) begin
          busy_q <= 1'b0;
          cnt_q  <= 4'h0;
          got_v  <= 1'b1;
          // released line must not look like a held bit
          rxd    <= ~rxd;
        end
      end
      // peer clock only within a word
      if (go) begin
        tog_q <= 5'h10;
        hc_q  <= 2'h0;
      end else if (tog_q == 5'h00) begin
        ext_clk <= ~pol;
      end else begin
        hc_q <= hc_q + 2'h1;
        if (hc_q == 2'h3) begin
          ext_clk <= ~ext_clk;
          tog_q   <= tog_q - 5'h01;
        end
      end
    end
  end
endmodule // cssc_peer
`default_nettype wire

/* File: verif/cssc_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cssc_cfg.svh"
module cssc_top_bench;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [`CSSC_AW-1:0]  addr = 8'h00;
  logic [`CSSC_DW-1:0]  wdata = 32'h0;
  logic                 wr = 1'b0, rd = 1'b0, rd_seen = 1'b0, cts_n = 1'b1;
  logic                 push = 1'b0, go = 1'b0, ext_mode = 1'b0, pol = 1'b0;
  logic [7:0]           push_d = 8'h00, got;
  logic [`CSSC_DW-1:0]  rdata, ev, mv, wv;
  logic                 tx_ready, rxd, ext_clk, got_v;
  logic [15:0]          half;
  logic [31:0]          seed = 32'h4A95;
  cssc_pkg::cssc_pins_s pins;
  int                   num_errors = 0, n_checks = 0, n_words = 0;
  logic [31:0]          rq[$], mq[$], wq[$];

  always #10 clk = ~clk;

  cssc_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tx_ready(tx_ready), .rxd_i(rxd), .cts_n_i(cts_n), .ext_clk_i(ext_clk), .pins_o(pins));

  cssc_peer u_peer (.clk(clk), .rst(rst), .pins(pins), .ext_mode(ext_mode), .pol(pol), .go(go),
    .push(push), .push_d(push_d), .rxd(rxd), .ext_clk(ext_clk), .got(got), .got_v(got_v), .half(half));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // wire order of a word for ctrl bits lsb_first, data_inv, pin_inv
  function automatic logic [7:0] wire_of(input logic [7:0] w, input logic [31:0] c);
    logic [7:0] v;
    v = w ^ {8{c[5]}};
    if (c[4]) v = {<<{v}};
    return v ^ {8{c[6]}};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one idle cycle after each strobe, so no signal is set twice in a step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back(e);
    mq.push_back(m);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic push_rx(input logic [7:0] v);
    push   <= 1'b1;
    push_d <= v;
    @(posedge clk);
    push <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_words(input int k);
    for (int j = 0; j < 4000 && n_words < k; j++) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    rd_seen <= rd;
    if (rd_seen) begin
      ev = rq.pop_front();
      mv = mq.pop_front();
      chk("rdata", ev & mv, rdata & mv);
    end
    if (got_v) begin
      n_words++;
      wv = wq.size() > 0 ? wq.pop_front() : 32'hXXXXXXXX;
      chk("wire word", wv, {8'h00, got, half});
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    finish_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] c, n, t, r, ctl;
    int          ps, hv;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("tx_ready", 32'h1, {31'h0, tx_ready});
    chk("pins", 32'h3E, {26'h0, pins});
    wr_reg(`CSSC_OFF_TXBUF, 32'h5A);
    wr_reg(8'h14, 32'h1FFF);
    wr_reg(`CSSC_OFF_DIV, 32'h1AB);
    rd_reg(`CSSC_OFF_CTRL, 32'h0, 32'hFFFFFFFF);
    rd_reg(`CSSC_OFF_DIV, 32'hAB, 32'hFFFFFFFF);
    rd_reg(`CSSC_OFF_TXBUF, 32'h0, 32'hFFFFFFFF);
    rd_reg(`CSSC_OFF_STAT, 32'h21, 32'hFFFFFFFF);
    rd_reg(8'h14, 32'h0, 32'hFFFFFFFF);
    // random modes, internal clock, one word each way
    for (int i = 0; i < 8; i++) begin
      c   = rnd();
      ctl = {19'h0, c[12:11], 1'b0, c[9], 1'b0, c[7:3], 3'h3};
      n   = (c[12:11] == 2'h0) ? 32'h2 + {31'h0, c[16]} : {31'h0, c[16]};
      ps  = (c[12:11] == 2'h0) ? 1 : ((c[12:11] == 2'h1) ? 8 : 32);
      hv  = (int'(n) + 1) * ps;
      t   = rnd() & 32'hFF;
      r   = rnd() & 32'hFF;
      pol <= c[3];
      wr_reg(`CSSC_OFF_CTRL, ctl);
      wr_reg(`CSSC_OFF_DIV, n);
      wr_reg(`CSSC_OFF_STAT, 32'h1C);
      chk("clk0_oe", {31'h0, ~c[9]}, {31'h0, pins.clk0_oe});
      chk("clk1_oe", {31'h0, c[9]}, {31'h0, pins.clk1_oe});
      push_rx(wire_of(r[7:0], ctl));
      wq.push_back({8'h00, wire_of(t[7:0], ctl), 16'(hv)});
      wr_reg(`CSSC_OFF_TXBUF, t);
      repeat (3) @(posedge clk);
      rd_reg(`CSSC_OFF_STAT, {28'h0, ~c[7], 3'h0}, 32'h9);
      wait_words(i + 1);
      repeat (4) @(posedge clk);
      rd_reg(`CSSC_OFF_STAT, 32'h1B, 32'h1F);
      rd_reg(`CSSC_OFF_RXBUF, r, 32'hFF);
      chk("txd idle", {31'h0, ~c[6]}, {31'h0, pins.txd});
    end
    // fastest internal rate, transmit only
    pol <= 1'b0;
    wr_reg(`CSSC_OFF_CTRL, 32'h1);
    wr_reg(`CSSC_OFF_DIV, 32'h0);
    t = rnd() & 32'hFF;
    wq.push_back({8'h00, t[7:0], 16'h0001});
    wr_reg(`CSSC_OFF_TXBUF, t);
    wait_words(9);
    // flow control holds a full buffer, then back-to-back words overrun
    wr_reg(`CSSC_OFF_CTRL, 32'h103);
    wr_reg(`CSSC_OFF_DIV, 32'h2);
    chk("rts_n", 32'h0, {31'h0, pins.rts_n});
    for (int k = 0; k < 9; k++) begin
      t = rnd() & 32'hFF;
      if (k < 8) begin
        r = rnd() & 32'hFF;
        push_rx(r[7:0]);
        wq.push_back({8'h00, t[7:0], 16'h0003});
      end
      wr_reg(`CSSC_OFF_TXBUF, t);
    end
    chk("tx_ready", 32'h0, {31'h0, tx_ready});
    rd_reg(`CSSC_OFF_STAT, 32'h41, 32'h61);
    cts_n <= 1'b0;
    wait_words(17);
    repeat (4) @(posedge clk);
    chk("rts_n", 32'h1, {31'h0, pins.rts_n});
    rd_reg(`CSSC_OFF_STAT, 32'h27, 32'h67);
    rd_reg(`CSSC_OFF_RXBUF, r, 32'hFF);
    wr_reg(`CSSC_OFF_STAT, 32'h4);
    rd_reg(`CSSC_OFF_STAT, 32'h0, 32'h4);
    // continuous receive on the peer clock
    ext_mode <= 1'b1;
    wr_reg(`CSSC_OFF_CTRL, 32'h407);
    wr_reg(`CSSC_OFF_TXBUF, 32'hFF);
    for (int k = 0; k < 3; k++) begin
      r = rnd() & 32'hFF;
      push_rx(r[7:0]);
      wq.push_back({16'h00FF, 16'h0004});
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait_words(18 + k);
      repeat (4) @(posedge clk);
      rd_reg(`CSSC_OFF_RXBUF, r, 32'hFF);
    end
    finish_test();
  end
endmodule // cssc_top_bench
`default_nettype wire
